// File: rtl/scpd_pkg.sv
package scpd_pkg;
	// Register offsets of the bank.
	localparam logic [15:0] ADDR_BITRATE_STATUS = 16'h001B;
	localparam logic [15:0] ADDR_OUT_COUNT_CFG = 16'h001C;
	localparam logic [15:0] ADDR_OUT_COUNT_STATUS = 16'h001D;
	localparam logic [15:0] ADDR_IN_COUNT_CFG = 16'h001E;
	localparam logic [15:0] ADDR_IN_COUNT_STATUS = 16'h001F;
	localparam logic [15:0] ADDR_MODULE_TYPE = 16'h0020;
	localparam logic [15:0] ADDR_SAFE_SELECT = 16'h0021;
	localparam logic [15:0] ADDR_VALIDITY_PERIOD = 16'h0022;

	// Reset values.
	localparam logic [7:0] COUNT_CFG_RESET = 8'h00;
	localparam logic [7:0] SAFE_SELECT_RESET = 8'h00;
	localparam logic [7:0] VALIDITY_RESET = 8'h00;
	// Module type code; the value is arbitrary.
	localparam logic [7:0] MODULE_TYPE_DEFAULT = 8'hA5;

	// Limits and field layout.
	localparam logic [7:0] COUNT_MAX = 8'h20;
	localparam int SAFE_CHAIN_LSB = 0;
	localparam int SAFE_FIELDBUS_LSB = 2;
	localparam int SAFE_SERIAL_LSB = 4;
	localparam logic [7:0] SAFE_SELECT_MASK = 8'h3F;

	// Chain mode codes.
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_AUTO = 3'h1;
	localparam logic [2:0] MODE_MANUAL = 3'h2;
	localparam logic [2:0] MODE_SLAVE = 3'h3;
	localparam logic [2:0] MODE_ERROR = 3'h4;

	// Safe value encodings.
	localparam logic [1:0] SAFE_ZEROS = 2'h0;
	localparam logic [1:0] SAFE_ONES = 2'h1;
	localparam logic [1:0] SAFE_HOLD = 2'h2;

	// Bitrate codes.
	localparam logic [15:0] RATE_NONE = 16'h0000;
	localparam logic [15:0] RATE_300K = 16'h0001;
	localparam logic [15:0] RATE_1200K = 16'h0002;
	localparam logic [15:0] RATE_4800K = 16'h0003;

	// Timing.
	localparam int CLK_HZ = 10000000;
	localparam int VALIDITY_UNIT_MS = 1;
	localparam int MS_TICK_CYCLES = CLK_HZ / 1000 * VALIDITY_UNIT_MS;
	localparam logic [1:0] SHIFT_HALF_CYCLES = 2'h2;
	localparam logic [7:0] RATE_SLOW_MIN = 8'h14;
	localparam logic [7:0] RATE_MID_MIN = 8'h05;
	localparam logic [7:0] RATE_FAST_MIN = 8'h02;
	localparam logic [7:0] RATE_TIMEOUT = 8'h64;

	// Data buffer.
	localparam int BUF_WIDTH = 8;
	localparam int BUF_DEPTH = 2;
endpackage

// File: rtl/scpd_buf_if.sv
`timescale 1ns/10ps
`default_nettype none
interface scpd_buf_if;
	logic [scpd_pkg::BUF_WIDTH-1:0] wr_data;
	logic wr_valid;
	logic wr_ready;
	logic [scpd_pkg::BUF_WIDTH-1:0] rd_data;
	logic rd_valid;
	logic rd_ready;
	modport store (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid);
	modport fill (output wr_data, wr_valid, input wr_ready);
	modport drain (input rd_data, rd_valid, output rd_ready);
endinterface
`default_nettype wire

// File: rtl/scpd_buf.sv
`timescale 1ns/10ps
`default_nettype none
module scpd_buf #(
	parameter int WIDTH = scpd_pkg::BUF_WIDTH,
	parameter int DEPTH = scpd_pkg::BUF_DEPTH
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_srst,
	// Buffer ports.
	scpd_buf_if.store bus
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	logic push;
	logic pop;

	assign bus.wr_ready = (count_r != (PW+1)'(DEPTH));
	assign bus.rd_valid = (count_r != '0);
	assign bus.rd_data = mem_r[rd_ptr_r];
	assign push = bus.wr_valid & bus.wr_ready;
	assign pop = bus.rd_valid & bus.rd_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= bus.wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // scpd_buf
`default_nettype wire

// File: rtl/scpd_top.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE_01: Bitrate status reads 0 when unset or invalid, else 1, 2, 3 by speed.
// RULE_02: Bitrate status is measured only in slave operation, from the external clock.
// RULE_03: Master operation accepts 0 to 32 output modules of 8 bits each.
// RULE_04: Master operation accepts 0 to 32 input modules of 8 bits each.
// RULE_05: Connected module count differing from the configured count puts the chain in error; the code checks this only in manual mode (2).
// RULE_06: Software must not select automatic detection when using manual counts.
// RULE_07: Count registers take effect only while master operation is active.
// RULE_08: Current output and input module counts are readable 16-bit values 0 to 32.
// RULE_09: A read-only 8-bit module type code is provided.
// RULE_10: Safe select bits 1:0 set chain outputs on data loss: zeros, ones, hold.
// RULE_11: Safe select bits 3:2 set fieldbus outputs on data loss, same encoding.
// RULE_12: Safe select bits 5:4 set serial port outputs; register resets to 0.
// RULE_13: A validity period of 1 to 255 counts milliseconds for the next production.
// RULE_14: A validity period of 0 disables expiry; data stays valid forever.
// RULE_15: Missing production within the period marks chain input data invalid.
// RULE_16: Outputs fed from an invalid input area switch to their safe values.
// RULE_17: Chain mode 0 off, 1 auto master, 2 manual master, 3 slave.
// RULE_18: Current mode status reads 4 when master operation is in error.
// RULE_19: The master shifts with lagging edge sampling, clock idle high, MSB first.
// RULE_20: A millisecond tick counter restarts on each production and expires at the period.
// RULE_21: Count writes above 32 are rejected and leave the stored count unchanged.
module scpd_top #(
	parameter int MS_TICKS = scpd_pkg::MS_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_srst,
	// Register access.
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_ack,
	output logic o_reg_err,
	// Chain configuration and status.
	input wire logic [2:0] i_chain_mode,
	input wire logic [5:0] i_found_out_count,
	input wire logic [5:0] i_found_in_count,
	output logic [2:0] o_chain_mode_status,
	output logic o_chain_in_valid,
	output logic [1:0] o_fieldbus_safe_sel,
	output logic [1:0] o_serial_port_safe_sel,
	// Output data toward the chain.
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	// Input data from the chain.
	output logic [7:0] o_rx_data,
	output logic o_rx_strobe,
	// Chain pins.
	input wire logic i_slave_sclk,
	input wire logic i_chain_miso,
	output logic o_chain_sclk,
	output logic o_chain_mosi
);
	typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} scpd_shift_t;

	scpd_buf_if tx_buf ();

	logic [7:0] out_cfg_r;
	logic [7:0] in_cfg_r;
	logic [7:0] safe_r;
	logic [7:0] period_r;
	logic [15:0] rdata_nxt;
	logic addr_ok;
	logic wr_bad;
	logic master_on;
	logic chain_err;
	logic [5:0] out_cur;
	logic [5:0] in_cur;
	logic [1:0] sclk_sync_r;
	logic [1:0] miso_sync_r;
	logic sclk_prev_r;
	logic [7:0] gap_r;
	logic [15:0] rate_r;
	logic [31:0] tick_r;
	logic [7:0] ms_r;
	logic valid_r;
	logic produced;
	scpd_shift_t state_r;
	logic [1:0] half_r;
	logic [2:0] bit_r;
	logic [7:0] tx_sh_r;
	logic [7:0] rx_sh_r;
	logic [7:0] last_tx_r;
	logic [7:0] load_byte;

	assign tx_buf.wr_data = i_tx_data;
	assign tx_buf.wr_valid = i_tx_valid;
	assign o_tx_ready = tx_buf.wr_ready;

	scpd_buf #(
		.WIDTH(scpd_pkg::BUF_WIDTH),
		.DEPTH(scpd_pkg::BUF_DEPTH)
	) u_tx_buf (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.bus(tx_buf.store)
	);

	// Register write side.
	always_comb begin
		unique case (i_reg_addr)
			scpd_pkg::ADDR_BITRATE_STATUS,
			scpd_pkg::ADDR_OUT_COUNT_CFG,
			scpd_pkg::ADDR_OUT_COUNT_STATUS,
			scpd_pkg::ADDR_IN_COUNT_CFG,
			scpd_pkg::ADDR_IN_COUNT_STATUS,
			scpd_pkg::ADDR_MODULE_TYPE,
			scpd_pkg::ADDR_SAFE_SELECT,
			scpd_pkg::ADDR_VALIDITY_PERIOD: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	always_comb begin
		wr_bad = 1'b0;
		if (!addr_ok) begin
			wr_bad = 1'b1;
		end else if ((i_reg_addr == scpd_pkg::ADDR_OUT_COUNT_CFG)
				|| (i_reg_addr == scpd_pkg::ADDR_IN_COUNT_CFG)) begin
			wr_bad = (i_reg_wdata > {8'h00, scpd_pkg::COUNT_MAX}); // RULE_21
		end else if ((i_reg_addr == scpd_pkg::ADDR_SAFE_SELECT)
				|| (i_reg_addr == scpd_pkg::ADDR_VALIDITY_PERIOD)) begin
			wr_bad = (i_reg_wdata[15:8] != 8'h00);
		end else begin
			wr_bad = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			out_cfg_r <= scpd_pkg::COUNT_CFG_RESET;
			in_cfg_r <= scpd_pkg::COUNT_CFG_RESET;
			safe_r <= scpd_pkg::SAFE_SELECT_RESET; // RULE_12
			period_r <= scpd_pkg::VALIDITY_RESET; // RULE_14
		end else if (i_reg_wr && !wr_bad) begin
			unique case (i_reg_addr)
				scpd_pkg::ADDR_OUT_COUNT_CFG: out_cfg_r <= i_reg_wdata[7:0]; // RULE_03
				scpd_pkg::ADDR_IN_COUNT_CFG: in_cfg_r <= i_reg_wdata[7:0]; // RULE_04
				scpd_pkg::ADDR_SAFE_SELECT: safe_r <= i_reg_wdata[7:0] & scpd_pkg::SAFE_SELECT_MASK;
				scpd_pkg::ADDR_VALIDITY_PERIOD: period_r <= i_reg_wdata[7:0]; // RULE_13
				default: ;
			endcase
		end
	end

	// Mode and module counts.
	always_comb begin
		master_on = (i_chain_mode == scpd_pkg::MODE_AUTO) || (i_chain_mode == scpd_pkg::MODE_MANUAL);
		out_cur = 6'h00;
		in_cur = 6'h00;
		chain_err = 1'b0;
		if (i_chain_mode == scpd_pkg::MODE_AUTO) begin
			// Detected counts override the written ones.
			out_cur = i_found_out_count; // RULE_06
			in_cur = i_found_in_count;
		end else if (i_chain_mode == scpd_pkg::MODE_MANUAL) begin
			out_cur = out_cfg_r[5:0]; // RULE_07
			in_cur = in_cfg_r[5:0];
			chain_err = (i_found_out_count != out_cfg_r[5:0])
				|| (i_found_in_count != in_cfg_r[5:0]); // RULE_05
		end
	end

	always_comb begin
		if (chain_err) begin
			o_chain_mode_status = scpd_pkg::MODE_ERROR; // RULE_18
		end else if (i_chain_mode > scpd_pkg::MODE_SLAVE) begin
			o_chain_mode_status = scpd_pkg::MODE_OFF;
		end else begin
			o_chain_mode_status = i_chain_mode; // RULE_17
		end
	end

	// Register read side.
	always_comb begin
		rdata_nxt = 16'h0000;
		unique case (i_reg_addr)
			scpd_pkg::ADDR_BITRATE_STATUS: rdata_nxt = rate_r;
			scpd_pkg::ADDR_OUT_COUNT_CFG: rdata_nxt = {8'h00, out_cfg_r};
			scpd_pkg::ADDR_OUT_COUNT_STATUS: rdata_nxt = {10'h000, out_cur}; // RULE_08
			scpd_pkg::ADDR_IN_COUNT_CFG: rdata_nxt = {8'h00, in_cfg_r};
			scpd_pkg::ADDR_IN_COUNT_STATUS: rdata_nxt = {10'h000, in_cur}; // RULE_08
			scpd_pkg::ADDR_MODULE_TYPE: rdata_nxt = {8'h00, scpd_pkg::MODULE_TYPE_DEFAULT}; // RULE_09
			scpd_pkg::ADDR_SAFE_SELECT: rdata_nxt = {8'h00, safe_r};
			scpd_pkg::ADDR_VALIDITY_PERIOD: rdata_nxt = {8'h00, period_r};
			default: rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_reg_rdata <= 16'h0000;
			o_reg_ack <= 1'b0;
			o_reg_err <= 1'b0;
		end else begin
			o_reg_ack <= i_reg_rd | i_reg_wr;
			o_reg_err <= (i_reg_rd && !addr_ok) || (i_reg_wr && wr_bad);
			if (i_reg_rd) begin
				o_reg_rdata <= rdata_nxt;
			end
		end
	end

	assign o_fieldbus_safe_sel = safe_r[scpd_pkg::SAFE_FIELDBUS_LSB +: 2]; // RULE_11
	assign o_serial_port_safe_sel = safe_r[scpd_pkg::SAFE_SERIAL_LSB +: 2]; // RULE_12

	// Pin synchronisers.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sclk_sync_r <= 2'h3;
			miso_sync_r <= 2'h0;
		end else begin
			sclk_sync_r <= {sclk_sync_r[0], i_slave_sclk};
			miso_sync_r <= {miso_sync_r[0], i_chain_miso};
		end
	end

	// Slave bitrate measurement from rising edge spacing.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sclk_prev_r <= 1'b1;
			gap_r <= 8'h00;
			rate_r <= scpd_pkg::RATE_NONE;
		end else begin
			sclk_prev_r <= sclk_sync_r[1];
			if (i_chain_mode != scpd_pkg::MODE_SLAVE) begin
				gap_r <= 8'h00;
				rate_r <= scpd_pkg::RATE_NONE; // RULE_02
			end else if (sclk_sync_r[1] && !sclk_prev_r) begin
				gap_r <= 8'h00;
				if (gap_r >= scpd_pkg::RATE_TIMEOUT) begin
					rate_r <= scpd_pkg::RATE_NONE; // RULE_01
				end else if (gap_r >= scpd_pkg::RATE_SLOW_MIN) begin
					rate_r <= scpd_pkg::RATE_300K;
				end else if (gap_r >= scpd_pkg::RATE_MID_MIN) begin
					rate_r <= scpd_pkg::RATE_1200K;
				end else if (gap_r >= scpd_pkg::RATE_FAST_MIN) begin
					rate_r <= scpd_pkg::RATE_4800K;
				end else begin
					rate_r <= scpd_pkg::RATE_NONE;
				end
			end else if (gap_r != 8'hFF) begin
				gap_r <= gap_r + 8'h01;
			end else begin
				rate_r <= scpd_pkg::RATE_NONE; // RULE_01
			end
		end
	end

	// Validity supervision in millisecond ticks.
	assign produced = o_rx_strobe;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tick_r <= 32'h0000_0000;
			ms_r <= 8'h00;
			valid_r <= 1'b1;
		end else if (period_r == 8'h00) begin
			tick_r <= 32'h0000_0000;
			ms_r <= 8'h00;
			valid_r <= 1'b1; // RULE_14
		end else if (produced) begin
			tick_r <= 32'h0000_0000;
			ms_r <= 8'h00; // RULE_20
			valid_r <= 1'b1;
		end else if (valid_r) begin
			if (tick_r == 32'(MS_TICKS - 1)) begin
				tick_r <= 32'h0000_0000;
				ms_r <= ms_r + 8'h01;
				if (ms_r + 8'h01 >= period_r) begin
					valid_r <= 1'b0; // RULE_15
				end
			end else begin
				tick_r <= tick_r + 32'h0000_0001;
			end
		end
	end

	assign o_chain_in_valid = valid_r;

	// Safe substitution of outgoing chain bytes.
	always_comb begin
		load_byte = tx_buf.rd_data;
		if (!valid_r) begin
			unique case (safe_r[scpd_pkg::SAFE_CHAIN_LSB +: 2]) // RULE_10
				scpd_pkg::SAFE_ZEROS: load_byte = 8'h00; // RULE_16
				scpd_pkg::SAFE_ONES: load_byte = 8'hFF;
				scpd_pkg::SAFE_HOLD: load_byte = last_tx_r;
				default: load_byte = 8'h00;
			endcase
		end
	end

	assign tx_buf.rd_ready = (state_r == SH_IDLE) && master_on && !chain_err;

	// Master shifter: data changes on the falling edge, sampled on the rising edge.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= SH_IDLE;
			half_r <= 2'h0;
			bit_r <= 3'h0;
			tx_sh_r <= 8'h00;
			rx_sh_r <= 8'h00;
			last_tx_r <= 8'h00;
			o_chain_sclk <= 1'b1;
			o_chain_mosi <= 1'b1;
			o_rx_data <= 8'h00;
			o_rx_strobe <= 1'b0;
		end else begin
			o_rx_strobe <= 1'b0;
			unique case (state_r)
				SH_IDLE: begin
					o_chain_sclk <= 1'b1; // RULE_19
					if (tx_buf.rd_valid && tx_buf.rd_ready) begin
						tx_sh_r <= load_byte;
						last_tx_r <= load_byte;
						o_chain_mosi <= load_byte[7]; // RULE_19
						o_chain_sclk <= 1'b0;
						bit_r <= 3'h0;
						half_r <= 2'h0;
						state_r <= SH_LOW;
					end
				end
				SH_LOW: begin
					if (half_r == scpd_pkg::SHIFT_HALF_CYCLES - 2'h1) begin
						half_r <= 2'h0;
						o_chain_sclk <= 1'b1;
						state_r <= SH_HIGH;
					end else begin
						half_r <= half_r + 2'h1;
					end
				end
				SH_HIGH: begin
					if (half_r == scpd_pkg::SHIFT_HALF_CYCLES - 2'h1) begin
						half_r <= 2'h0;
						if (bit_r == 3'h7) begin
							o_rx_data <= rx_sh_r;
							o_rx_strobe <= 1'b1;
							state_r <= SH_IDLE;
						end else begin
							bit_r <= bit_r + 3'h1;
							tx_sh_r <= {tx_sh_r[6:0], 1'b0};
							o_chain_mosi <= tx_sh_r[6];
							o_chain_sclk <= 1'b0;
							state_r <= SH_LOW;
						end
					end else begin
						// The synchroniser lags the pin by two cycles, so the bit at the rising edge is read here.
						rx_sh_r <= {rx_sh_r[6:0], miso_sync_r[1]}; // RULE_19
						half_r <= half_r + 2'h1;
					end
				end
			endcase
		end
	end
endmodule // scpd_top
`default_nettype wire

// File: tb/scpd_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module scpd_monitor #(
	parameter int MS_TICKS = 10
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_srst,
	// Watched ports.
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic o_reg_ack,
	input wire logic o_reg_err,
	input wire logic [2:0] i_chain_mode,
	input wire logic [2:0] o_chain_mode_status,
	input wire logic o_chain_in_valid,
	input wire logic o_rx_strobe,
	input wire logic o_tx_ready,
	input wire logic o_chain_sclk,
	input wire logic o_chain_mosi
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_low_half;
		!o_chain_sclk ##1 !o_chain_sclk ##1 o_chain_sclk;
	endsequence
	a_ack_follows_req: assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack)
		else $error("ack missing after request");
	a_ack_has_cause: assert property (o_reg_ack |-> $past(i_reg_rd || i_reg_wr))
		else $error("ack without request");
	a_err_with_ack: assert property (o_reg_err |-> o_reg_ack)
		else $error("err without ack");
	a_count_over_limit: assert property (i_reg_wr && i_reg_addr == scpd_pkg::ADDR_OUT_COUNT_CFG
		&& i_reg_wdata > 16'h0020 |=> o_reg_err) else $error("count above limit accepted");
	a_type_read_only: assert property (i_reg_wr && i_reg_addr == scpd_pkg::ADDR_MODULE_TYPE
		|=> o_reg_err) else $error("type code write accepted");
	a_mode_status_echo: assert property (i_chain_mode inside {3'h0, 3'h1, 3'h3}
		|-> o_chain_mode_status == i_chain_mode) else $error("mode status wrong");
	a_strobe_revalid: assert property (o_rx_strobe |=> o_chain_in_valid)
		else $error("valid not restored by production");
	a_strobe_one_cycle: assert property (o_rx_strobe |=> !o_rx_strobe)
		else $error("rx strobe too long");
	a_sclk_low_half: assert property ($fell(o_chain_sclk) |-> s_low_half)
		else $error("sclk low phase not two cycles");
	a_reset_idle_high: assert property ($fell(i_srst) |-> o_chain_sclk && o_chain_mosi
		&& o_tx_ready) else $error("idle levels wrong after reset");
endmodule // scpd_monitor
bind scpd_top scpd_monitor #(.MS_TICKS(MS_TICKS)) mon_u (.i_clk, .i_srst, .i_reg_rd, .i_reg_wr,
	.i_reg_addr, .i_reg_wdata, .o_reg_ack, .o_reg_err, .i_chain_mode, .o_chain_mode_status,
	.o_chain_in_valid, .o_rx_strobe, .o_tx_ready, .o_chain_sclk, .o_chain_mosi);
`default_nettype wire

// File: tb/scpd_chain_model.sv
`timescale 1ns/10ps
`default_nettype none
module scpd_chain_model (
	// Reset.
	input wire logic i_srst,
	// Chain pins.
	input wire logic i_sclk,
	input wire logic i_mosi,
	output logic o_miso,
	// Content of the modelled module.
	input wire logic [7:0] i_pattern,
	output logic [7:0] o_got
);
	int cnt;
	initial o_miso = 1'b0;
	initial o_got = 8'h00;
	initial cnt = 0;
	// Data moves on the falling edge and is captured on the rising edge, MSB first.
	always @(i_sclk) begin
		if (i_srst) begin
			cnt = 0;
		end else if (i_sclk === 1'b0) begin
			o_miso <= i_pattern[3'(7 - cnt)];
		end else if (i_sclk === 1'b1) begin
			o_got <= {o_got[6:0], i_mosi};
			// Outside a frame the line no longer shows the last bit.
			if (cnt == 7) begin
				cnt = 0;
				o_miso <= ~o_miso;
			end else begin
				cnt = cnt + 1;
			end
		end
	end
endmodule // scpd_chain_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic i_clk, i_srst, i_reg_rd, i_reg_wr, i_tx_valid, i_slave_sclk, i_chain_miso;
	logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic o_reg_ack, o_reg_err, o_chain_in_valid, o_tx_ready, o_rx_strobe, o_chain_sclk;
	logic o_chain_mosi;
	logic [2:0] i_chain_mode, o_chain_mode_status;
	logic [5:0] i_found_out_count, i_found_in_count;
	logic [1:0] o_fieldbus_safe_sel, o_serial_port_safe_sel;
	logic [7:0] i_tx_data, o_rx_data, pattern, got;
	int bad_count, checked, cyc;
	scpd_top #(.MS_TICKS(20)) dut_u (.i_clk, .i_srst, .i_reg_rd, .i_reg_wr, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_reg_err, .i_chain_mode, .i_found_out_count,
		.i_found_in_count, .o_chain_mode_status, .o_chain_in_valid, .o_fieldbus_safe_sel,
		.o_serial_port_safe_sel, .i_tx_data, .i_tx_valid, .o_tx_ready, .o_rx_data, .o_rx_strobe,
		.i_slave_sclk, .i_chain_miso, .o_chain_sclk, .o_chain_mosi);
	scpd_chain_model chain_u (.i_srst, .i_sclk(o_chain_sclk), .i_mosi(o_chain_mosi),
		.o_miso(i_chain_miso), .i_pattern(pattern), .o_got(got));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc > 5000) begin
			bad_count++;
			finish_test();
		end
	end
	task chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, d, exp, input logic e);
		@(posedge i_clk);
		i_reg_wr <= w;
		i_reg_rd <= !w;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
		#1;
		chk("ack", 16'h0001, {15'h0000, o_reg_ack});
		chk("err", {15'h0000, e}, {15'h0000, o_reg_err});
		if (!w) chk("rdata", exp, o_reg_rdata);
	endtask
	task set_chain(input logic [2:0] m, input logic [5:0] fo, fi);
		@(posedge i_clk);
		i_chain_mode <= m;
		i_found_out_count <= fo;
		i_found_in_count <= fi;
		@(posedge i_clk);
		#1;
	endtask
	task wait_rx(input logic [7:0] exp);
		int n;
		n = 0;
		while (o_rx_strobe !== 1'b1 && n < 200) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk("rx_strobe", 16'h0001, {15'h0000, o_rx_strobe});
		chk("rx_data", {8'h00, pattern}, {8'h00, o_rx_data});
		chk("chain_out", {8'h00, exp}, {8'h00, got});
	endtask
	task t_reset;
		logic [7:0] rv [8];
		rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, scpd_pkg::MODULE_TYPE_DEFAULT, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) acc(0, 16'h001B + 16'(i), 0, {8'h00, rv[i]}, 0);
		acc(0, 16'h0023, 0, 0, 1);
	endtask
	task t_cfg;
		acc(1, scpd_pkg::ADDR_OUT_COUNT_CFG, 16'h0020, 0, 0);
		acc(1, scpd_pkg::ADDR_OUT_COUNT_CFG, 16'h0021, 0, 1);
		acc(0, scpd_pkg::ADDR_OUT_COUNT_CFG, 0, 16'h0020, 0);
		acc(1, scpd_pkg::ADDR_IN_COUNT_CFG, 16'h0021, 0, 1);
		acc(0, scpd_pkg::ADDR_IN_COUNT_CFG, 0, 16'h0000, 0);
		acc(1, scpd_pkg::ADDR_MODULE_TYPE, 16'h0011, 0, 1);
		acc(1, scpd_pkg::ADDR_OUT_COUNT_STATUS, 16'h0001, 0, 1);
		acc(1, scpd_pkg::ADDR_SAFE_SELECT, 16'h00FF, 0, 0);
		acc(0, scpd_pkg::ADDR_SAFE_SELECT, 0, 16'h003F, 0);
		acc(1, scpd_pkg::ADDR_SAFE_SELECT, 16'h0024, 0, 0);
		chk("fb_sel", 16'h0001, {14'h0000, o_fieldbus_safe_sel});
		chk("sp_sel", 16'h0002, {14'h0000, o_serial_port_safe_sel});
	endtask
	task t_modes;
		acc(1, scpd_pkg::ADDR_OUT_COUNT_CFG, 16'h0001, 0, 0);
		acc(1, scpd_pkg::ADDR_IN_COUNT_CFG, 16'h0001, 0, 0);
		set_chain(scpd_pkg::MODE_MANUAL, 6'h01, 6'h01);
		chk("mode_st", 16'h0002, {13'h0000, o_chain_mode_status});
		acc(0, scpd_pkg::ADDR_IN_COUNT_STATUS, 0, 16'h0001, 0);
		set_chain(scpd_pkg::MODE_MANUAL, 6'h01, 6'h02);
		chk("mode_st", 16'h0004, {13'h0000, o_chain_mode_status});
		set_chain(scpd_pkg::MODE_AUTO, 6'h03, 6'h02);
		acc(0, scpd_pkg::ADDR_OUT_COUNT_STATUS, 0, 16'h0003, 0);
		acc(0, scpd_pkg::ADDR_IN_COUNT_STATUS, 0, 16'h0002, 0);
		set_chain(scpd_pkg::MODE_OFF, 6'h01, 6'h01);
		acc(0, scpd_pkg::ADDR_OUT_COUNT_STATUS, 0, 16'h0000, 0);
		set_chain(3'h5, 6'h01, 6'h01);
		chk("mode_st", 16'h0000, {13'h0000, o_chain_mode_status});
		set_chain(scpd_pkg::MODE_OFF, 6'h01, 6'h01);
	endtask
	task t_buffer;
		@(posedge i_clk);
		i_tx_valid <= 1'b1;
		i_tx_data <= 8'h3C;
		@(posedge i_clk);
		i_tx_data <= 8'hC3;
		@(posedge i_clk);
		i_tx_valid <= 1'b0;
		#1;
		chk("tx_ready", 16'h0000, {15'h0000, o_tx_ready});
		set_chain(scpd_pkg::MODE_MANUAL, 6'h01, 6'h01);
		wait_rx(8'h3C);
		@(posedge i_clk);
		#1;
		wait_rx(8'hC3);
	endtask
	task t_valid;
		logic [7:0] ev [3];
		ev = '{8'hC3, 8'hFF, 8'h00};
		acc(1, scpd_pkg::ADDR_VALIDITY_PERIOD, 16'h0001, 0, 0);
		for (int i = 0; i < 3; i++) begin
			repeat (40) @(posedge i_clk);
			#1;
			chk("in_valid", 0, {15'h0000, o_chain_in_valid});
			acc(1, scpd_pkg::ADDR_SAFE_SELECT, 16'h0002 - 16'(i), 0, 0);
			@(posedge i_clk);
			i_tx_valid <= 1'b1;
			i_tx_data <= 8'h5A;
			@(posedge i_clk);
			i_tx_valid <= 1'b0;
			wait_rx(ev[i]);
			@(posedge i_clk);
			#1;
			chk("in_valid", 16'h0001, {15'h0000, o_chain_in_valid});
		end
		acc(1, scpd_pkg::ADDR_VALIDITY_PERIOD, 16'h0000, 0, 0);
		repeat (60) @(posedge i_clk);
		#1;
		chk("in_valid", 16'h0001, {15'h0000, o_chain_in_valid});
	endtask
	task t_rate;
		set_chain(scpd_pkg::MODE_SLAVE, 6'h00, 6'h00);
		chk("mode_st", 16'h0003, {13'h0000, o_chain_mode_status});
		fork
			begin
				repeat (30) begin
					repeat (4) @(posedge i_clk);
					i_slave_sclk <= 1'b1;
					repeat (4) @(posedge i_clk);
					i_slave_sclk <= 1'b0;
				end
			end
			begin
				repeat (150) @(posedge i_clk);
				acc(0, scpd_pkg::ADDR_BITRATE_STATUS, 0, scpd_pkg::RATE_1200K, 0);
			end
		join
		set_chain(scpd_pkg::MODE_OFF, 6'h00, 6'h00);
		acc(0, scpd_pkg::ADDR_BITRATE_STATUS, 0, scpd_pkg::RATE_NONE, 0);
	endtask
	initial begin
		{i_reg_rd, i_reg_wr, i_tx_valid, i_slave_sclk} = 4'h0;
		{i_reg_addr, i_reg_wdata, i_tx_data} = 40'h0;
		i_chain_mode = scpd_pkg::MODE_OFF;
		{i_found_out_count, i_found_in_count} = 12'h000;
		pattern = 8'h96;
		{bad_count, checked, cyc} = 0;
		i_srst = 1'b1;
		repeat (5) @(posedge i_clk);
		i_srst <= 1'b0;
		t_reset();
		t_cfg();
		t_modes();
		t_buffer();
		t_valid();
		t_rate();
		finish_test();
	end
endmodule // testbench
`default_nettype wire
